// file: include/tt_pkg.sv
/*
 * Shared constants of the second-capture/reload timer: register indices,
 * control bit positions, reset values and bus widths.
 * Assumes byte addresses on the bus are four times the register index.
 */
package tt_pkg;
   // Bus shape
   localparam int ADDR_W = 10;
   localparam int DATA_W = 32;
   localparam int IDX_W = 8;

   // Register indices; the byte address is four times the index
   localparam logic [7:0] IDX_CONTROL = 8'hc8;
   localparam logic [7:0] IDX_RCAP_LOW = 8'hca;
   localparam logic [7:0] IDX_RCAP_HIGH = 8'hcb;
   localparam logic [7:0] IDX_COUNT_LOW = 8'hcc;
   localparam logic [7:0] IDX_COUNT_HIGH = 8'hcd;
   localparam logic [7:0] IDX_IRQ_STATUS = 8'hd0;
   localparam logic [7:0] IDX_IRQ_CLEAR = 8'hd1;
   localparam logic [7:0] IDX_IRQ_ENABLE = 8'hd2;

   // Control register bit positions
   localparam int BIT_OVERFLOW_FLAG = 7;
   localparam int BIT_EXT_EVENT_FLAG = 6;
   localparam int BIT_RECEIVE_CLOCK_SELECT = 5;
   localparam int BIT_TRANSMIT_CLOCK_SELECT = 4;
   localparam int BIT_EXT_TRIGGER_ENABLE = 3;
   localparam int BIT_RUN_CONTROL = 2;
   localparam int BIT_COUNTER_FUNCTION_SELECT = 1;
   localparam int BIT_CAPTURE_SELECT = 0;

   // Interrupt status bit positions
   localparam int IRQ_BIT_OVERFLOW = 0;
   localparam int IRQ_BIT_EXT_EVENT = 1;
   localparam int IRQ_W = 2;

   // Reset values and the count maximum
   localparam logic [7:0] RST_CONTROL = 8'h00;
   localparam logic [7:0] RST_COUNT = 8'h00;
   localparam logic [7:0] RST_RCAP = 8'h00;
   localparam logic [1:0] RST_IRQ = 2'h0;
   localparam logic [15:0] COUNT_MAX = 16'hffff;
endpackage : tt_pkg

// file: logic/tt_edge_sync.sv
/*
 * Two-stage synchroniser for one input pin with a falling-edge detector.
 * Assumes the pin may change at any time relative to mclk_i.
 */
`timescale 1ns/1ps
module tt_edge_sync (
   // Clock and reset
   input wire logic mclk_i,
   input wire logic resetn_i,
   // Pin and result
   input wire logic pin_i,
   output logic fall_o
);
   logic meta_r;
   logic sync_r;
   logic prev_r;

   // Pins idle high, so reset to 1 avoids a false edge after release
   always_ff @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         meta_r <= 1'b1;
         sync_r <= 1'b1;
         prev_r <= 1'b1;
      end else begin
         meta_r <= pin_i;
         sync_r <= meta_r;
         prev_r <= sync_r;
      end
   end

   assign fall_o = prev_r & ~sync_r; // see R16
endmodule : tt_edge_sync

// file: logic/tt_irq.sv
/*
 * Sticky interrupt status with write-one-to-clear and enable registers.
 * Assumes event inputs are one-cycle pulses and writes are single cycle.
 */
`timescale 1ns/1ps
module tt_irq (
   // Clock and reset
   input wire logic mclk_i,
   input wire logic resetn_i,
   // Events
   input wire logic [tt_pkg::IRQ_W-1:0] event_i,
   // Software access
   input wire logic clear_we_i,
   input wire logic enable_we_i,
   input wire logic [tt_pkg::IRQ_W-1:0] wdata_i,
   // State
   output logic [tt_pkg::IRQ_W-1:0] status_o,
   output logic [tt_pkg::IRQ_W-1:0] enable_o,
   output logic irq_o
);
   logic [tt_pkg::IRQ_W-1:0] status_nxt;

   // A new event beats a clear in the same cycle
   always_comb begin
      status_nxt = status_o;
      if (clear_we_i) begin
         status_nxt = status_o & ~wdata_i;
      end
      status_nxt = status_nxt | event_i;
   end

   always_ff @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         status_o <= tt_pkg::RST_IRQ;
      end else begin
         status_o <= status_nxt;
      end
   end

   always_ff @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         enable_o <= tt_pkg::RST_IRQ;
      end else if (enable_we_i) begin
         enable_o <= wdata_i;
      end
   end

   always_ff @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         irq_o <= 1'b0;
      end else begin
         irq_o <= |(status_nxt & (enable_we_i ? wdata_i : enable_o));
      end
   end
endmodule : tt_irq

// file: logic/tt_timer.sv
/*
 * Sixteen-bit timer/counter with auto-reload, capture and serial baud
 * tick generation, reached over an Avalon-MM slave with waitrequest.
 * Assumes one clock domain; trigger and count pins are asynchronous
 * and are synchronised here; the other timer's overflow is a pulse
 * synchronous to mclk_i.
 */
`timescale 1ns/1ps

// Functional notes
// R1: Counter rollover sets overflow flag, bit 7.
// R2: Serial clock select blocks overflow flag setting.
// R3: Flags stay set until software clears.
// R4: Trigger-caused capture or reload sets event flag.
// R5: Bit 5 picks receive tick source.
// R6: Bit 4 picks transmit tick source.
// R7: Trigger enable works only outside baud mode.
// R8: Counting happens only while run bit set.
// R9: Bit 1 selects pin events or clock.
// R10: Capture select captures on trigger falling edge.
// R11: Reload mode reloads on overflow and trigger.
// R12: Baud mode forces reload on every overflow.
// R13: Count bytes and control reset zero, writable.
// R14: Reload loads count from reload/capture pair.
// R15: Capture copies count into reload/capture pair.
// R16: Pins synchronised, falling edges from samples.
// R17: Software count writes beat hardware updates.
module tt_timer (
   // Clock and reset
   input wire logic mclk_i,
   input wire logic resetn_i,
   // Avalon-MM slave
   input wire logic [tt_pkg::ADDR_W-1:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [tt_pkg::DATA_W-1:0] avs_writedata_i,
   input wire logic [3:0] avs_byteenable_i,
   output logic [tt_pkg::DATA_W-1:0] avs_readdata_o,
   output logic avs_waitrequest_o,
   // Pins
   input wire logic trigger_pin_i,
   input wire logic count_pin_i,
   // Serial port clocking
   input wire logic other_timer_ovf_i,
   output logic rx_baud_tick_o,
   output logic tx_baud_tick_o,
   // Status outputs
   output logic overflow_pulse_o,
   output logic irq_o
);
   // Control register fields
   logic [7:0] control;
   logic [5:0] setup_r;
   logic overflow_flag_r;
   logic external_event_flag_r;
   logic receive_clock_select;
   logic transmit_clock_select;
   logic external_trigger_enable;
   logic run_control;
   logic counter_function_select;
   logic capture_select;

   // Count and reload/capture state
   logic [7:0] count_low_r;
   logic [7:0] count_high_r;
   logic [7:0] rcap_low_r;
   logic [7:0] rcap_high_r;
   logic [15:0] count_now;
   logic [15:0] count_nxt;
   logic [15:0] rcap_now;

   // Bus decode
   logic [tt_pkg::IDX_W-1:0] idx;
   logic wr_ok;
   logic rd_take;
   logic wr_lane0;
   logic [7:0] wbyte;
   logic we_control;
   logic we_count_low;
   logic we_count_high;
   logic we_rcap_low;
   logic we_rcap_high;
   logic we_irq_clear;
   logic we_irq_enable;
   logic [31:0] rd_mux;

   // Event terms
   logic trig_fall;
   logic count_fall;
   logic baud_mode;
   logic tick;
   logic overflow;
   logic ext_event;
   logic do_capture;
   logic do_reload;
   logic set_overflow_flag;
   logic [15:0] count_inc;
   logic rx_src;
   logic tx_src;
   logic [tt_pkg::IRQ_W-1:0] irq_events;
   logic [tt_pkg::IRQ_W-1:0] irq_status;
   logic [tt_pkg::IRQ_W-1:0] irq_enable;

   assign control = {overflow_flag_r, external_event_flag_r, setup_r};
   assign receive_clock_select = control[tt_pkg::BIT_RECEIVE_CLOCK_SELECT];
   assign transmit_clock_select = control[tt_pkg::BIT_TRANSMIT_CLOCK_SELECT];
   assign external_trigger_enable = control[tt_pkg::BIT_EXT_TRIGGER_ENABLE];
   assign run_control = control[tt_pkg::BIT_RUN_CONTROL];
   assign counter_function_select = control[tt_pkg::BIT_COUNTER_FUNCTION_SELECT];
   assign capture_select = control[tt_pkg::BIT_CAPTURE_SELECT];

   assign count_now = {count_high_r, count_low_r};
   assign rcap_now = {rcap_high_r, rcap_low_r};

   // Pin conditioning
   // A pin fall acts three clocks late; levels under one clock may be lost
   tt_edge_sync u_trig_sync (
      .mclk_i(mclk_i),
      .resetn_i(resetn_i),
      .pin_i(trigger_pin_i),
      .fall_o(trig_fall)
   );

   tt_edge_sync u_count_sync (
      .mclk_i(mclk_i),
      .resetn_i(resetn_i),
      .pin_i(count_pin_i),
      .fall_o(count_fall)
   );

   // Bus decode: a write lands only at the edge where waitrequest is low
   assign idx = avs_address_i[tt_pkg::ADDR_W-1:2];
   assign wr_ok = avs_write_i & ~avs_waitrequest_o;
   assign rd_take = avs_read_i & avs_waitrequest_o;
   assign wr_lane0 = wr_ok & avs_byteenable_i[0];
   assign wbyte = avs_writedata_i[7:0];
   assign we_control = wr_lane0 && (idx == tt_pkg::IDX_CONTROL);
   assign we_count_low = wr_lane0 && (idx == tt_pkg::IDX_COUNT_LOW);
   assign we_count_high = wr_lane0 && (idx == tt_pkg::IDX_COUNT_HIGH);
   assign we_rcap_low = wr_lane0 && (idx == tt_pkg::IDX_RCAP_LOW);
   assign we_rcap_high = wr_lane0 && (idx == tt_pkg::IDX_RCAP_HIGH);
   assign we_irq_clear = wr_lane0 && (idx == tt_pkg::IDX_IRQ_CLEAR);
   assign we_irq_enable = wr_lane0 && (idx == tt_pkg::IDX_IRQ_ENABLE);

   // Mode and event terms
   assign baud_mode = receive_clock_select | transmit_clock_select;

   // Counter input: pin falling edges or every core clock
   assign tick = run_control & (counter_function_select ? count_fall : 1'b1); // see R8, R9

   assign overflow = tick && (count_now == tt_pkg::COUNT_MAX);

   // The trigger pin is ignored while the timer clocks the serial port
   assign ext_event = trig_fall & external_trigger_enable & ~baud_mode; // see R7

   assign do_capture = ext_event & capture_select; // see R10

   // Baud mode overrides capture select; overflow reloads too
   assign do_reload = (overflow & (baud_mode | ~capture_select)) // see R11, R12
                    | (ext_event & ~capture_select); // see R11

   assign set_overflow_flag = overflow & ~baud_mode; // see R1, R2

   // Rolls over to zero in capture mode, where no reload follows
   assign count_inc = count_now + 16'h0001;

   // Next count, hardware view only
   always_comb begin
      count_nxt = count_now;
      if (do_reload) begin
         count_nxt = rcap_now; // see R14
      end else if (tick) begin
         count_nxt = count_inc;
      end
   end

   // Count bytes; a software write to a byte beats hardware on that byte
   always_ff @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         count_low_r <= tt_pkg::RST_COUNT; // see R13
      end else if (we_count_low) begin
         count_low_r <= wbyte; // see R17
      end else begin
         count_low_r <= count_nxt[7:0];
      end
   end

   always_ff @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         count_high_r <= tt_pkg::RST_COUNT; // see R13
      end else if (we_count_high) begin
         count_high_r <= wbyte; // see R17
      end else begin
         count_high_r <= count_nxt[15:8];
      end
   end

   // Reload/capture pair; capture leaves the count running
   always_ff @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         rcap_low_r <= tt_pkg::RST_RCAP;
      end else if (we_rcap_low) begin
         rcap_low_r <= wbyte; // see R17
      end else if (do_capture) begin
         rcap_low_r <= count_low_r; // see R15
      end
   end

   always_ff @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         rcap_high_r <= tt_pkg::RST_RCAP;
      end else if (we_rcap_high) begin
         rcap_high_r <= wbyte; // see R17
      end else if (do_capture) begin
         rcap_high_r <= count_high_r; // see R15
      end
   end

   // Mode bits move only under software control
   always_ff @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         setup_r <= tt_pkg::RST_CONTROL[tt_pkg::BIT_RECEIVE_CLOCK_SELECT:0]; // see R13
      end else if (we_control) begin
         setup_r <= wbyte[tt_pkg::BIT_RECEIVE_CLOCK_SELECT:0];
      end
   end

   // Flags are only ever cleared by software; a hardware set wins
   always_ff @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         overflow_flag_r <= tt_pkg::RST_CONTROL[tt_pkg::BIT_OVERFLOW_FLAG]; // see R13
      end else if (set_overflow_flag) begin
         overflow_flag_r <= 1'b1; // see R1, R3
      end else if (we_control) begin
         overflow_flag_r <= wbyte[tt_pkg::BIT_OVERFLOW_FLAG];
      end
   end

   always_ff @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         external_event_flag_r <= tt_pkg::RST_CONTROL[tt_pkg::BIT_EXT_EVENT_FLAG]; // see R13
      end else if (ext_event) begin
         external_event_flag_r <= 1'b1; // see R4, R3
      end else if (we_control) begin
         external_event_flag_r <= wbyte[tt_pkg::BIT_EXT_EVENT_FLAG];
      end
   end

   // Serial port tick selection; the other timer's pulse passes when not selected
   assign rx_src = receive_clock_select ? overflow : other_timer_ovf_i; // see R5
   assign tx_src = transmit_clock_select ? overflow : other_timer_ovf_i; // see R6

   always_ff @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         rx_baud_tick_o <= 1'b0;
      end else begin
         rx_baud_tick_o <= rx_src; // see R5
      end
   end

   always_ff @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         tx_baud_tick_o <= 1'b0;
      end else begin
         tx_baud_tick_o <= tx_src; // see R6
      end
   end

   // Raw rollover pulse, also in baud mode where no flag is set
   always_ff @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         overflow_pulse_o <= 1'b0;
      end else begin
         overflow_pulse_o <= overflow;
      end
   end

   // Interrupts follow flag set events, not flag levels
   assign irq_events[tt_pkg::IRQ_BIT_OVERFLOW] = set_overflow_flag;
   assign irq_events[tt_pkg::IRQ_BIT_EXT_EVENT] = ext_event;

   tt_irq u_irq (
      .mclk_i(mclk_i),
      .resetn_i(resetn_i),
      .event_i(irq_events),
      .clear_we_i(we_irq_clear),
      .enable_we_i(we_irq_enable),
      .wdata_i(wbyte[tt_pkg::IRQ_W-1:0]),
      .status_o(irq_status),
      .enable_o(irq_enable),
      .irq_o(irq_o)
   );

   // Read mux; unmapped and write-only offsets read zero
   always_comb begin
      rd_mux = 32'h0000_0000;
      case (idx)
         tt_pkg::IDX_CONTROL: begin
            rd_mux[7:0] = control;
         end
         tt_pkg::IDX_RCAP_LOW: begin
            rd_mux[7:0] = rcap_low_r;
         end
         tt_pkg::IDX_RCAP_HIGH: begin
            rd_mux[7:0] = rcap_high_r;
         end
         tt_pkg::IDX_COUNT_LOW: begin
            rd_mux[7:0] = count_low_r;
         end
         tt_pkg::IDX_COUNT_HIGH: begin
            rd_mux[7:0] = count_high_r;
         end
         tt_pkg::IDX_IRQ_STATUS: begin
            rd_mux[tt_pkg::IRQ_W-1:0] = irq_status;
         end
         tt_pkg::IDX_IRQ_ENABLE: begin
            rd_mux[tt_pkg::IRQ_W-1:0] = irq_enable;
         end
         default: begin
            rd_mux = 32'h0000_0000;
         end
      endcase
   end

   // Read data are captured at the edge where waitrequest drops and held
   always_ff @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         avs_readdata_o <= 32'h0000_0000;
      end else if (rd_take) begin
         avs_readdata_o <= rd_mux;
      end
   end

   // Waitrequest idles high and drops for one cycle per request
   always_ff @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         avs_waitrequest_o <= 1'b1;
      end else begin
         avs_waitrequest_o <= ~((avs_read_i | avs_write_i) & avs_waitrequest_o);
      end
   end

   // Reading a count byte while running returns that instant's value;
   // a 16-bit read across two accesses can tear at a byte carry.
endmodule : tt_timer

// file: tb/tt_pins_model.sv
/*
 * Far-side model: trigger pin, count pin and the other timer's overflow.
 * Assumes tasks are called just after a rising edge of mclk_i.
 */
`timescale 1ns/1ps
module tt_pins (
   // Clock
   input wire logic mclk_i,
   // Pins
   output logic trig_o,
   output logic cnt_o,
   output logic ovf_o
);
   initial begin
      trig_o = 1'b1;
      cnt_o = 1'b1;
      ovf_o = 1'b0;
   end

   // Each trigger and count pin level stands four cycles so the synchroniser cannot miss it
   task fall_trig();
      trig_o <= 1'b0;
      repeat (4) @(posedge mclk_i);
      trig_o <= 1'b1;
      repeat (4) @(posedge mclk_i);
   endtask : fall_trig

   task pulse_cnt();
      cnt_o <= 1'b0;
      repeat (4) @(posedge mclk_i);
      cnt_o <= 1'b1;
      repeat (4) @(posedge mclk_i);
   endtask : pulse_cnt

   task pulse_ovf();
      ovf_o <= 1'b1;
      @(posedge mclk_i);
      ovf_o <= 1'b0;
      @(posedge mclk_i);
   endtask : pulse_ovf
endmodule : tt_pins

// file: tb/tt_timer_props.sv
/*
 * Port checker for tt_timer, bound to the top module.
 * Assumes control and enable writes are seen only through the bus.
 */
`timescale 1ns/1ps
module tt_timer_chk (
   // Clock and reset
   input wire logic mclk_i,
   input wire logic resetn_i,
   // Bus
   input wire logic [tt_pkg::ADDR_W-1:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [tt_pkg::DATA_W-1:0] avs_writedata_i,
   input wire logic [3:0] avs_byteenable_i,
   input wire logic avs_waitrequest_o,
   // Serial clocking and status
   input wire logic other_timer_ovf_i,
   input wire logic rx_baud_tick_o,
   input wire logic tx_baud_tick_o,
   input wire logic overflow_pulse_o,
   input wire logic irq_o
);
   logic [7:0] ctl_r;
   logic [1:0] en_r;
   logic wr_ack;
   logic baud;
   assign wr_ack = avs_write_i && !avs_waitrequest_o && avs_byteenable_i[0];
   assign baud = ctl_r[5] | ctl_r[4];

   // Shadow of the software view; hardware flags are not needed here
   always_ff @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         ctl_r <= 8'h00;
         en_r <= 2'h0;
      end else if (wr_ack && avs_address_i[9:2] == tt_pkg::IDX_CONTROL) begin
         ctl_r <= avs_writedata_i[7:0];
      end else if (wr_ack && avs_address_i[9:2] == tt_pkg::IDX_IRQ_ENABLE) begin
         en_r <= avs_writedata_i[1:0];
      end
   end

   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (!resetn_i);

   sequence s_req;
      (avs_read_i || avs_write_i) && avs_waitrequest_o;
   endsequence
   sequence s_ack;
      !avs_waitrequest_o ##1 avs_waitrequest_o;
   endsequence

   property p_wait_one;
      s_req |=> s_ack;
   endproperty
   a_wait_one: assert property (p_wait_one) else $error("wait not one cycle");
   property p_idle_wait;
      !avs_read_i && !avs_write_i |=> avs_waitrequest_o;
   endproperty
   a_idle_wait: assert property (p_idle_wait) else $error("wait low when idle");
   property p_run_gate;
      overflow_pulse_o |-> $past(ctl_r[2]) || $past(ctl_r[2], 2);
   endproperty
   a_run_gate: assert property (p_run_gate) else $error("overflow while stopped");
   property p_rx_own;
      ctl_r[5] && overflow_pulse_o |-> rx_baud_tick_o;
   endproperty
   a_rx_own: assert property (p_rx_own) else $error("rx tick missing");
   property p_rx_other;
      $past(other_timer_ovf_i) && !ctl_r[5] && !$past(ctl_r[5]) |-> rx_baud_tick_o;
   endproperty
   a_rx_other: assert property (p_rx_other) else $error("rx tick not from other");
   property p_tx_own;
      ctl_r[4] && overflow_pulse_o |-> tx_baud_tick_o;
   endproperty
   a_tx_own: assert property (p_tx_own) else $error("tx tick missing");
   property p_tx_other;
      $past(other_timer_ovf_i) && !ctl_r[4] && !$past(ctl_r[4]) |-> tx_baud_tick_o;
   endproperty
   a_tx_other: assert property (p_tx_other) else $error("tx tick not from other");
   property p_ovf_irq;
      overflow_pulse_o && !$past(baud) && en_r[0] |-> ##[0:2] irq_o;
   endproperty
   a_ovf_irq: assert property (p_ovf_irq) else $error("overflow irq missing");
   property p_baud_noirq;
      overflow_pulse_o && $past(baud) && en_r == 2'b01 && $past(en_r) == 2'b01
         && !$past(irq_o) |-> !irq_o [*2];
   endproperty
   a_baud_noirq: assert property (p_baud_noirq) else $error("irq in baud mode");
   property p_irq_sticky;
      $fell(irq_o) |-> $past(wr_ack) || $past(wr_ack, 2);
   endproperty
   a_irq_sticky: assert property (p_irq_sticky) else $error("irq fell unasked");
endmodule : tt_timer_chk

bind tt_timer tt_timer_chk tt_timer_chk_i (.mclk_i, .resetn_i, .avs_address_i,
   .avs_read_i, .avs_write_i, .avs_writedata_i, .avs_byteenable_i,
   .avs_waitrequest_o, .other_timer_ovf_i, .rx_baud_tick_o, .tx_baud_tick_o,
   .overflow_pulse_o, .irq_o);

// file: tb/tt_timer_tb.sv
/*
 * Self-checking bench for tt_timer over its Avalon-MM slave.
 * Assumes the pin model tt_pins and the bound checker.
 */
`timescale 1ns/1ps
module tt_timer_tb;
   localparam logic [7:0] CT = tt_pkg::IDX_CONTROL;
   localparam logic [7:0] RL = tt_pkg::IDX_RCAP_LOW;
   localparam logic [7:0] RH = tt_pkg::IDX_RCAP_HIGH;
   localparam logic [7:0] CL = tt_pkg::IDX_COUNT_LOW;
   localparam logic [7:0] CH = tt_pkg::IDX_COUNT_HIGH;
   localparam logic [7:0] IC = tt_pkg::IDX_IRQ_CLEAR;
   localparam logic [7:0] IE = tt_pkg::IDX_IRQ_ENABLE;
   logic mclk_i = 1'b0;
   logic resetn_i = 1'b0;
   logic [9:0] adr = 10'h000;
   logic rd = 1'b0;
   logic wr = 1'b0;
   logic [31:0] wdata = 32'h0;
   logic [31:0] rdata;
   logic waitr, rxt, txt, ovp, irq, trig, cnt, oth;
   logic [7:0] v;
   logic [7:0] ix [5] = '{CT, RL, RH, CL, CH};
   int miscompares = 0;
   int checks_done = 0;
   int n_ovf = 0;
   int n_rx = 0;
   int n_tx = 0;
   int b_ovf, b_rx, b_tx;

   always #10 mclk_i = ~mclk_i;

   // Pulse counters for the one-cycle outputs
   always @(posedge mclk_i) begin
      n_ovf <= n_ovf + int'(ovp === 1'b1);
      n_rx <= n_rx + int'(rxt === 1'b1);
      n_tx <= n_tx + int'(txt === 1'b1);
   end

   tt_timer tt_timer_i (.mclk_i, .resetn_i, .avs_address_i(adr), .avs_read_i(rd),
      .avs_write_i(wr), .avs_writedata_i(wdata), .avs_byteenable_i(4'hf),
      .avs_readdata_o(rdata), .avs_waitrequest_o(waitr), .trigger_pin_i(trig),
      .count_pin_i(cnt), .other_timer_ovf_i(oth), .rx_baud_tick_o(rxt),
      .tx_baud_tick_o(txt), .overflow_pulse_o(ovp), .irq_o(irq));
   tt_pins tt_pins_i (.mclk_i, .trig_o(trig), .cnt_o(cnt), .ovf_o(oth));

   task summarize();
      $display("checks %0d mismatches %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : summarize

   task chk(input logic [7:0] got, input logic [7:0] exp);
      checks_done++;
      if (got !== exp) begin
         miscompares++;
         $display("MISMATCH %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk

   // One bus transfer; the request stands until waitrequest is seen low
   task acc(input logic [7:0] idx, input logic w, input logic [7:0] d);
      int n;
      n = 0;
      adr <= {idx, 2'b00};
      wdata <= {24'h0, d};
      rd <= !w;
      wr <= w;
      @(posedge mclk_i);
      while (waitr !== 1'b0) begin
         n++;
         if (n > 50) begin
            miscompares++;
            summarize();
         end
         @(posedge mclk_i);
      end
      v = rdata[7:0];
      rd <= 1'b0;
      wr <= 1'b0;
      @(posedge mclk_i);
   endtask : acc

   task rdc(input logic [7:0] idx, input logic [7:0] exp);
      acc(idx, 1'b0, 8'h00);
      chk(v, exp);
   endtask : rdc

   task chkirq(input logic exp);
      repeat (2) @(posedge mclk_i);
      chk({7'h0, irq}, {7'h0, exp});
   endtask : chkirq

   initial begin
      repeat (20000) @(posedge mclk_i);
      miscompares++;
      summarize();
   end

   initial begin
      repeat (6) @(posedge mclk_i);
      resetn_i <= 1'b1;
      @(posedge mclk_i);
      foreach (ix[i]) rdc(ix[i], 8'h00);
      rdc(8'hc0, 8'h00);
      acc(CL, 1'b1, 8'h5a);
      rdc(CL, 8'h5a);
      $display("test reset and access done");
      acc(RL, 1'b1, 8'h00);
      acc(RH, 1'b1, 8'h80);
      acc(CL, 1'b1, 8'hfe);
      acc(CH, 1'b1, 8'hff);
      acc(IE, 1'b1, 8'h01);
      repeat (20) @(posedge mclk_i);
      rdc(CL, 8'hfe);
      b_ovf = n_ovf;
      acc(CT, 1'b1, 8'h04);
      repeat (20) @(posedge mclk_i);
      rdc(CT, 8'h84);
      rdc(CH, 8'h80);
      chkirq(1'b1);
      chk(8'(n_ovf - b_ovf), 8'h01);
      acc(IE, 1'b1, 8'h00);
      chkirq(1'b0);
      acc(IE, 1'b1, 8'h01);
      chkirq(1'b1);
      acc(IC, 1'b1, 8'h01);
      chkirq(1'b0);
      acc(CT, 1'b1, 8'h00);
      $display("test overflow reload done");
      acc(CL, 1'b1, 8'h34);
      acc(CH, 1'b1, 8'h12);
      acc(CT, 1'b1, 8'h09);
      tt_pins_i.fall_trig();
      rdc(RL, 8'h34);
      rdc(RH, 8'h12);
      rdc(CL, 8'h34);
      rdc(CT, 8'h49);
      acc(RL, 1'b1, 8'hcd);
      acc(RH, 1'b1, 8'hab);
      acc(CT, 1'b1, 8'h08);
      tt_pins_i.fall_trig();
      rdc(CL, 8'hcd);
      rdc(CH, 8'hab);
      rdc(CT, 8'h48);
      $display("test trigger done");
      acc(IC, 1'b1, 8'h03);
      acc(RL, 1'b1, 8'hfe);
      acc(RH, 1'b1, 8'hff);
      acc(CL, 1'b1, 8'hfe);
      acc(CH, 1'b1, 8'hff);
      acc(CT, 1'b1, 8'h3c);
      tt_pins_i.fall_trig();
      chkirq(1'b0);
      rdc(CT, 8'h3c);
      rdc(CH, 8'hff);
      acc(CT, 1'b1, 8'h00);
      $display("test baud done");
      acc(CL, 1'b1, 8'h00);
      acc(CT, 1'b1, 8'h06);
      b_rx = n_rx;
      b_tx = n_tx;
      repeat (3) begin
         tt_pins_i.pulse_cnt();
         tt_pins_i.pulse_ovf();
      end
      rdc(CL, 8'h03);
      chk(8'(n_rx - b_rx), 8'h03);
      chk(8'(n_tx - b_tx), 8'h03);
      acc(CT, 1'b1, 8'h00);
      $display("test counter done");
      summarize();
   end
endmodule : tt_timer_tb
